//--- hdl/smw_pkg.sv
// shared constants for the static memory wait extension block
package smw_pkg;
   localparam int          ADDR_W       = 24;
   localparam int          DATA_W       = 16;
   localparam int          LANE_W       = 2;
   localparam int          WS_W         = 5;
   localparam logic [4:0]  WS_MIN_HOLD  = 5'h02;
   localparam logic [1:0]  DONE_CYCLES  = 2'h3;
   localparam logic [1:0]  RECOG_CYCLES = 2'h2;
   localparam logic [ADDR_W-1:0] ADDR_RST = 24'h00_0000;
   localparam logic [LANE_W-1:0] LANE_OFF_N = 2'h3;
   typedef enum logic [1:0] {
      SMW_IDLE,
      SMW_WAIT,
      SMW_DONE
   } smw_state_e;
endpackage : smw_pkg

//--- hdl/smw_wait_ext.sv
// static memory access sequencer with external hold extension
// Contract
// - sample the hold input every clock of an access
// - cycle of chip select assertion is the first wait state
// - asserted hold is recognised within two clocks
// - wait phase lasts N clocks or until hold is seen high again, later wins
// - after hold release the access finishes in three clocks
// - only the byte lanes being transferred are enabled
`timescale 1ns/10ps
module smw_wait_ext (
   // clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        arst_n,
   // internal request side
   input  wire logic                        req_valid,
   input  wire logic                        req_write,
   input  wire logic [smw_pkg::ADDR_W-1:0]  req_addr,
   input  wire logic [smw_pkg::LANE_W-1:0]  req_lanes,
   input  wire logic [smw_pkg::WS_W-1:0]    req_wait_states,
   output logic                             req_ready_ff,
   output logic                             req_done_ff,
   // external memory side
   input  wire logic                        ext_hold_n,
   output logic                             bank_select_n_ff,
   output logic                             write_en_n_ff,
   output logic                             output_en_n_ff,
   output logic [smw_pkg::ADDR_W-1:0]       mem_addr_ff,
   output logic [smw_pkg::LANE_W-1:0]       byte_lane_en_n_ff
);
   smw_pkg::smw_state_e               state_ff;
   smw_pkg::smw_state_e               nxt_state;
   logic [smw_pkg::WS_W-1:0]          ws_cnt_ff;
   logic [smw_pkg::WS_W-1:0]          nxt_ws_cnt;
   logic [1:0]                        done_cnt_ff;
   logic [1:0]                        nxt_done_cnt;
   logic                              hold_seen_ff;
   logic                              nxt_hold_seen;
   logic                              nxt_select_n;
   logic                              nxt_write_en_n;
   logic                              nxt_output_en_n;
   logic [smw_pkg::ADDR_W-1:0]        nxt_addr;
   logic [smw_pkg::LANE_W-1:0]        nxt_lanes_n;
   logic                              nxt_ready;
   logic                              nxt_done;
   logic [smw_pkg::WS_W-1:0]          ws_prog_ff;
   logic [smw_pkg::WS_W-1:0]          nxt_ws_prog;

   // one register stage of the hold input gives recognition in two clocks
   always_comb begin
      nxt_hold_seen    = ~ext_hold_n;
      nxt_state        = state_ff;
      nxt_ws_cnt       = ws_cnt_ff;
      nxt_done_cnt     = done_cnt_ff;
      nxt_select_n     = bank_select_n_ff;
      nxt_write_en_n   = write_en_n_ff;
      nxt_output_en_n  = output_en_n_ff;
      nxt_addr         = mem_addr_ff;
      nxt_lanes_n      = byte_lane_en_n_ff;
      nxt_ready        = 1'b0;
      nxt_done         = 1'b0;
      nxt_ws_prog      = ws_prog_ff;
      unique case (state_ff)
         smw_pkg::SMW_IDLE: begin
            nxt_ready = 1'b1;
            if (req_valid && req_ready_ff) begin
               nxt_ready       = 1'b0;
               nxt_state       = smw_pkg::SMW_WAIT;
               nxt_select_n    = 1'b0;
               nxt_write_en_n  = ~req_write;
               nxt_output_en_n = req_write;
               nxt_addr        = req_addr;
               nxt_lanes_n     = ~req_lanes;
               nxt_ws_prog     = req_wait_states;
               // select cycle is counted as wait state one
               nxt_ws_cnt      = 5'h01;
            end
         end
         smw_pkg::SMW_WAIT: begin
            if (ws_cnt_ff != 5'h1f) begin
               nxt_ws_cnt = ws_cnt_ff + 5'h01;
            end
            // leave only when count reached and hold idle now and last clock
            // raw sample: catches a hold that starts in the last count cycle
            // registered sample: release is taken one clock after it rises
            if (ws_cnt_ff >= ws_prog_ff && ext_hold_n
                  && !hold_seen_ff) begin
               nxt_state    = smw_pkg::SMW_DONE;
               nxt_done_cnt = 2'h1;
            end
         end
         smw_pkg::SMW_DONE: begin
            // signals held through completion
            nxt_done_cnt = done_cnt_ff + 2'h1;
            if (done_cnt_ff == smw_pkg::DONE_CYCLES) begin
               nxt_state       = smw_pkg::SMW_IDLE;
               nxt_select_n    = 1'b1;
               nxt_write_en_n  = 1'b1;
               nxt_output_en_n = 1'b1;
               nxt_lanes_n     = smw_pkg::LANE_OFF_N;
               nxt_done_cnt    = 2'h0;
               nxt_done        = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_ff          <= smw_pkg::SMW_IDLE;
         ws_cnt_ff         <= 5'h00;
         done_cnt_ff       <= 2'h0;
         hold_seen_ff      <= 1'b0;
         bank_select_n_ff  <= 1'b1;
         write_en_n_ff     <= 1'b1;
         output_en_n_ff    <= 1'b1;
         mem_addr_ff       <= smw_pkg::ADDR_RST;
         byte_lane_en_n_ff <= smw_pkg::LANE_OFF_N;
         req_ready_ff      <= 1'b0;
         req_done_ff       <= 1'b0;
         ws_prog_ff        <= 5'h00;
      end else begin
         state_ff          <= nxt_state;
         ws_cnt_ff         <= nxt_ws_cnt;
         done_cnt_ff       <= nxt_done_cnt;
         hold_seen_ff      <= nxt_hold_seen;
         bank_select_n_ff  <= nxt_select_n;
         write_en_n_ff     <= nxt_write_en_n;
         output_en_n_ff    <= nxt_output_en_n;
         mem_addr_ff       <= nxt_addr;
         byte_lane_en_n_ff <= nxt_lanes_n;
         req_ready_ff      <= nxt_ready;
         req_done_ff       <= nxt_done;
         ws_prog_ff        <= nxt_ws_prog;
      end
   end

   // all checks run on the system clock and rest during reset
   default clocking cb_sys @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   // exit of the wait phase: count met, hold idle now and one clock ago
   sequence s_release;
      state_ff == smw_pkg::SMW_WAIT && ws_cnt_ff >= ws_prog_ff
         && ext_hold_n && !hold_seen_ff;
   endsequence

   // three completion cycles with select low, then select rises with done
   sequence s_finish;
      (state_ff == smw_pkg::SMW_DONE && !bank_select_n_ff) [*3]
         ##1 (req_done_ff && bank_select_n_ff);
   endsequence

   // hold driven low while the wait phase runs
   sequence s_hold_low;
      state_ff == smw_pkg::SMW_WAIT && !ext_hold_n;
   endsequence

   // a request taken on this edge
   sequence s_taken;
      req_valid && req_ready_ff;
   endsequence

   a_hold_sampled: assert property (
      hold_seen_ff == !$past(ext_hold_n))
      else $error("hold sample not registered");

   a_first_wait: assert property (
      $fell(bank_select_n_ff) |-> ws_cnt_ff == 5'h01)
      else $error("select cycle not counted as first wait");

   a_wait_count: assert property (
      (state_ff == smw_pkg::SMW_WAIT && ws_cnt_ff < ws_prog_ff)
         |=> ws_cnt_ff == $past(ws_cnt_ff) + 5'h01)
      else $error("wait count did not advance");

   a_hold_recog: assert property (
      s_hold_low |=> (state_ff == smw_pkg::SMW_WAIT) [*2])
      else $error("asserted hold not recognised");

   a_wait_min: assert property (
      (state_ff == smw_pkg::SMW_WAIT && ws_cnt_ff < ws_prog_ff)
         |=> state_ff == smw_pkg::SMW_WAIT)
      else $error("wait phase ended before programmed count");

   a_wait_hold: assert property (
      (state_ff == smw_pkg::SMW_WAIT && hold_seen_ff)
         |=> state_ff == smw_pkg::SMW_WAIT)
      else $error("wait phase ended while hold active");

   a_done_three: assert property (
      s_release |=> s_finish)
      else $error("access not finished three clocks after release");

   a_lanes_match: assert property (
      s_taken |=> byte_lane_en_n_ff == ~$past(req_lanes))
      else $error("byte lanes do not match request");

   a_addr_taken: assert property (
      s_taken |=> !bank_select_n_ff && mem_addr_ff == $past(req_addr))
      else $error("select or address not set by request");

   a_lanes_idle: assert property (
      bank_select_n_ff |-> byte_lane_en_n_ff == smw_pkg::LANE_OFF_N)
      else $error("byte lane active outside access");

   a_stable_addr: assert property (
      (!bank_select_n_ff && !$rose(bank_select_n_ff)
         && !$fell(bank_select_n_ff)) |-> $stable(mem_addr_ff)
         && $stable(byte_lane_en_n_ff))
      else $error("address or lanes moved during access");

   a_strobe_stable: assert property (
      (!bank_select_n_ff && !$fell(bank_select_n_ff))
         |-> $stable(write_en_n_ff) && $stable(output_en_n_ff))
      else $error("strobe moved during access");

endmodule : smw_wait_ext

//--- sim/smw_mem_model.sv
// external memory model that stretches accesses with its hold output
`timescale 1ns/10ps
module smw_mem_model (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   // hold timing chosen by the bench
   input  wire logic [4:0] hold_delay,
   input  wire logic [5:0] hold_len,
   // memory side
   input  wire logic       bank_select_n,
   output logic            ext_hold_n
);
   logic [6:0] cyc_ff;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) cyc_ff <= 7'h00;
      else if (bank_select_n) cyc_ff <= 7'h00;
      else cyc_ff <= cyc_ff + 7'h01;
   end
   // pulled up: a released hold reads inactive, never the last value
   assign ext_hold_n = !(!bank_select_n && hold_len != 6'h00
      && cyc_ff >= {2'h0, hold_delay}
      && cyc_ff < {2'h0, hold_delay} + {1'h0, hold_len});
   // hold is driven low only, idle level high
endmodule : smw_mem_model

//--- sim/static_memory_wait_extension_tb.sv
// self-checking bench for the static memory wait extension
`timescale 1ns/10ps
module static_memory_wait_extension_tb;
   logic        clk_sys, arst_n, req_valid, req_write, ext_hold_n;
   logic        req_ready_ff, req_done_ff, bank_select_n_ff, write_en_n_ff;
   logic        output_en_n_ff;
   logic [23:0] req_addr, mem_addr_ff;
   logic [1:0]  req_lanes, byte_lane_en_n_ff;
   logic [4:0]  req_wait_states, hold_delay;
   logic [5:0]  hold_len;
   int          mismatches, num_checks, cycles;
   smw_wait_ext i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
      .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_lanes(req_lanes), .req_wait_states(req_wait_states),
      .req_ready_ff(req_ready_ff), .req_done_ff(req_done_ff),
      .ext_hold_n(ext_hold_n), .bank_select_n_ff(bank_select_n_ff),
      .write_en_n_ff(write_en_n_ff), .output_en_n_ff(output_en_n_ff),
      .mem_addr_ff(mem_addr_ff), .byte_lane_en_n_ff(byte_lane_en_n_ff));
   smw_mem_model i_mem (.clk_sys(clk_sys), .arst_n(arst_n),
      .hold_delay(hold_delay), .hold_len(hold_len),
      .bank_select_n(bank_select_n_ff), .ext_hold_n(ext_hold_n));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   // whole run needs about 130 cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   // done is seen t negedges after the taking edge; must fall in lo..hi
   task automatic access(input logic wr, input logic [1:0] ln,
      input logic [4:0] n, dl, input logic [5:0] hl, input int lo, hi);
      int          t;
      logic [23:0] a;
      a = 24'hA5_5A00 + {19'h0_0000, n};
      @(negedge clk_sys);
      while (req_ready_ff !== 1'b1) @(negedge clk_sys);
      @(posedge clk_sys);
      {req_valid, req_write, req_lanes, req_wait_states} <= {1'b1, wr, ln, n};
      req_addr <= a;
      hold_delay <= dl;
      hold_len <= hl;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      t = 0;
      do begin
         @(negedge clk_sys);
         t++;
         if (t == 1) chk("select_low", bank_select_n_ff, 0);
         if (bank_select_n_ff === 1'b0) begin
            chk("addr", mem_addr_ff, a);
            chk("lanes", byte_lane_en_n_ff, {~ln});
            chk("strobes", {write_en_n_ff, output_en_n_ff},
               {~wr, wr});
         end
      end while (req_done_ff !== 1'b1 && t < 60);
      chk("done_time", t >= lo && t <= hi, 1);
      chk("idle_pins", {bank_select_n_ff, byte_lane_en_n_ff},
         3'h7);
      @(negedge clk_sys);
      chk("done_pulse", req_done_ff, 0);
   endtask : access
   task automatic t_reset;
      chk("rst_pins", {req_ready_ff, bank_select_n_ff, byte_lane_en_n_ff},
         4'h7);
   endtask : t_reset
   // no hold: select cycle plus N-1 counts, three to finish, then done
   task automatic t_plain;
      access(1'b0, 2'h1, 5'h02, 5'h00, 6'h00, 6, 6);
      access(1'b1, 2'h2, 5'h05, 5'h00, 6'h00, 9, 9);
      access(1'b1, 2'h3, 5'h1F, 5'h00, 6'h00, 35, 35);
   endtask : t_plain
   // hold right after select with the minimum count
   task automatic t_hold_two;
      access(1'b0, 2'h3, 5'h02, 5'h01, 6'h06, 12, 16);
   endtask : t_hold_two
   // short hold inside a long count: the count wins
   task automatic t_hold_short;
      access(1'b1, 2'h1, 5'h14, 5'h02, 6'h03, 24, 24);
   endtask : t_hold_short
   // latest allowed hold start for eight wait states
   task automatic t_hold_late;
      access(1'b0, 2'h2, 5'h08, 5'h07, 6'h04, 16, 20);
   endtask : t_hold_late
   initial begin
      {arst_n, req_valid, req_write, req_lanes} = 5'h00;
      req_addr = 24'h00_0000;
      req_wait_states = 5'h00;
      hold_delay = 5'h00;
      hold_len = 6'h00;
      {mismatches, num_checks, cycles} = '0;
      repeat (2) @(posedge clk_sys);
      t_reset();
      arst_n <= 1'b1;
      t_plain();
      t_hold_two();
      t_hold_short();
      t_hold_late();
      final_report();
   end
endmodule : static_memory_wait_extension_tb
